// >>> rtl/gwc_consts.svh
// Purpose: constants of the gain word control interface
// Assumes: included by bare name after the package
// Notes:   byte addresses of the apb register map and field positions
`ifndef GWC_CONSTS_SVH
`define GWC_CONSTS_SVH

`define GWC_WORD_W          9
`define GWC_FINE_LSB        0
`define GWC_COARSE_LSB      4
`define GWC_DIR_BIT         8
`define GWC_COARSE_STEP     9'h00f
`define GWC_GAIN_REF_WORD   9'h100

`define GWC_ADDR_W          8
`define GWC_OFS_CTRL        8'h00
`define GWC_OFS_GAIN        8'h04
`define GWC_OFS_SHIFT       8'h08
`define GWC_OFS_STATUS      8'h0c

`define GWC_CTRL_SER_ONLY   0
`define GWC_CTRL_FORCE_PD   1
`define GWC_ST_MODE         9
`define GWC_ST_PD           10
`define GWC_ST_SCK          11
`define GWC_ST_TENTHS_LSB   16
`define GWC_ST_TENTHS_MSB   25

`define GWC_PIN_W           11
`define GWC_PIN_RST         11'h400
`define GWC_LATCH_RST       9'h000
`define GWC_SHIFT_RST       9'h000

`endif

// >>> rtl/gwc_pkg.sv
// Purpose: shared types of the gain word control interface
// Assumes: nothing
// Notes:   numeric constants live in gwc_consts.svh
package gwc_pkg;
  typedef logic [8:0] gwc_word_t;
  typedef logic signed [9:0] gwc_tenths_t;
  typedef enum logic {
    GWC_PARALLEL,
    GWC_SERIAL
  } gwc_mode_e;
endpackage

// >>> rtl/gwc_sync.sv
// Purpose: two flip-flop synchroniser for a group of pin levels
// Assumes: each bit is an independent level
// Notes:   reset value is a parameter so pulled pins start at their rest
`timescale 1ns/1ps
module gwc_sync #(
  parameter int              W   = 1,
  parameter logic [W-1:0]    RST = '0
) (
  input  wire logic          clk,
  input  wire logic          rstn,
  input  wire logic [W-1:0]  data_in,
  output logic      [W-1:0]  data_out
);
  logic [W-1:0] meta;

  // meta feeds only data_out
  always_ff @(posedge clk) begin
    if (!rstn) begin
      meta     <= RST;
      data_out <= RST;
    end else begin
      meta     <= data_in;
      data_out <= meta;
    end
  end
endmodule

// >>> rtl/gwc_gain_ctrl.sv
// Purpose: digital control section of a logarithmic gain/attenuator
// Assumes: all pins are asynchronous to clk; link clock far below clk
// Notes:   shared pins change role with the interface mode
//
// Summary of operation
// RULE1: one gain setting is held as a nine-bit control word.
// RULE2: settings span -24 to +24 dB in tenth-decibel steps.
// RULE3: interface select high means serial, low means parallel.
// RULE4: the serial-only variant has no parallel mode at all.
// RULE5: serial input bit is captured on each shift clock rising edge.
// RULE6: shift register output advances on each shift clock falling edge.
// RULE7: serial output pin shows the output stage while in serial mode.
// RULE8: load-in strobe copies shift register into the gain latch.
// RULE9: read-back strobe copies the gain latch into the shift register.
// RULE10: serial mode ignores the unused coarse, fine and direction pins.
// RULE11: parallel mode takes the four coarse bits straight from pins.
// RULE12: parallel mode takes the four fine bits straight from pins.
// RULE13: parallel mode takes the direction bit straight from its pin.
// RULE14: powerdown input high powers down, low runs normally.
// RULE15: undriven interface select reads high, other inputs read low.
// RULE16: direction one with all other bits zero is the 0 dB word.
// RULE17: controller pulses strobes only while the shift clock is low.
// RULE18: first bit shifted in becomes bit zero of the word.
// RULE19: coarse bits give 0 to 22.5 dB in 1.5 dB steps; direction.
// RULE20: fine bits give 0 to 1.5 dB in 0.1 dB steps, same direction.
// RULE21: gain latch and shift register start at all zero.
`timescale 1ns/1ps
`include "gwc_consts.svh"
module gwc_gain_ctrl #(
  parameter logic                SERIAL_ONLY = 1'b0
) (
  input  wire logic                  clk,
  input  wire logic                  rstn,
  input  wire logic [`GWC_ADDR_W-1:0] paddr,
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [31:0]           pwdata,
  output logic      [31:0]           prdata,
  output logic                       pready,
  output logic                       pslverr,
  input  wire logic                  interface_select,
  input  wire logic                  power_down_in,
  input  wire logic                  direction_select,
  input  wire logic                  coarse_sel_3,
  input  wire logic                  coarse_sel_2,
  input  wire logic                  coarse_sel_1,
  input  wire logic                  coarse_sel_0,
  input  wire logic                  fine_sel_3,
  input  wire logic                  fine_sel_2,
  input  wire logic                  fine_sel_1,
  input  wire logic                  fine_sel_0_in,
  output logic                       fine_sel_0_out,
  output logic                       fine_sel_0_oe,
  output gwc_pkg::gwc_word_t         gain_word,
  output gwc_pkg::gwc_tenths_t       gain_tenths,
  output logic                       power_down,
  output logic                       serial_mode
);
  import gwc_pkg::*;

  // signed tenths of a decibel; attenuation is negative
  function automatic gwc_tenths_t word_tenths(input gwc_word_t w);
    logic [8:0] coarse;
    logic [8:0] mag;
    coarse = {5'h00, w[`GWC_COARSE_LSB +: 4]};
    // coarse step is fifteen tenths, fine step one tenth
    mag    = coarse * `GWC_COARSE_STEP
             + {5'h00, w[`GWC_FINE_LSB +: 4]}; // see RULE19 RULE20
    // direction one with zero magnitude gives 0 dB
    if (w[`GWC_DIR_BIT]) begin // see RULE16
      word_tenths = -$signed({1'b0, mag});
    end else begin
      word_tenths = $signed({1'b0, mag});
    end
  endfunction

  logic [`GWC_PIN_W-1:0] pins_raw;
  logic [`GWC_PIN_W-1:0] pins_s;
  logic                  iface_s;
  logic                  pdn_s;
  logic                  dir_s;
  logic [3:0]            coarse_s;
  logic [3:0]            fine_s;
  logic                  sck_d;
  logic                  sck_rise;
  logic                  sck_fall;
  logic                  load_in_strobe_s;
  logic                  readback_strobe_s;
  logic                  sin_s;
  logic                  sck_s;
  gwc_mode_e             mode;
  gwc_word_t             shift_q;
  gwc_word_t             latch_q;
  gwc_word_t             next_word;
  logic                  sod_q;
  logic                  ctrl_ser_only;
  logic                  ctrl_force_pd;
  logic                  apb_setup;
  logic                  apb_wr;
  logic                  hit;
  logic [31:0]           next_rdata;

  assign pins_raw = {interface_select, power_down_in, direction_select,
                     coarse_sel_3, coarse_sel_2, coarse_sel_1,
                     coarse_sel_0, fine_sel_3, fine_sel_2, fine_sel_1,
                     fine_sel_0_in};

  // reset value keeps interface select high and the rest low, as the
  // pull resistors would leave them
  gwc_sync #(
    .W   (`GWC_PIN_W),
    .RST (`GWC_PIN_RST)
  ) u_pin_sync (
    .clk      (clk),
    .rstn     (rstn),
    .data_in  (pins_raw),
    .data_out (pins_s)
  ); // see RULE15

  assign iface_s  = pins_s[10];
  assign pdn_s    = pins_s[9];
  assign dir_s    = pins_s[8];
  assign coarse_s = pins_s[7:4];
  assign fine_s   = pins_s[3:0];

  // serial roles of the shared pins
  assign load_in_strobe_s = coarse_s[2];
  assign sin_s  = coarse_s[1];
  assign readback_strobe_s = coarse_s[0];
  assign sck_s  = fine_s[2];

  // interface mode; serial-only variant never falls to parallel
  always_comb begin
    if (ctrl_ser_only || iface_s) begin // see RULE3 RULE4
      mode = GWC_SERIAL;
    end else begin
      mode = GWC_PARALLEL;
    end
  end

  assign serial_mode = (mode == GWC_SERIAL);

  // shift clock edge finder, on the synchronised level only
  always_ff @(posedge clk) begin
    if (!rstn) begin
      sck_d <= 1'b0;
    end else begin
      sck_d <= sck_s;
    end
  end

  assign sck_rise = serial_mode && sck_s && !sck_d;
  assign sck_fall = serial_mode && !sck_s && sck_d;

  // shift register; read-back load wins over a shift because the
  // strobe is only legal with the shift clock low
  always_ff @(posedge clk) begin
    if (!rstn) begin
      shift_q <= `GWC_SHIFT_RST; // see RULE21
    end else if (serial_mode && readback_strobe_s) begin
      shift_q <= latch_q; // see RULE9 RULE17
    end else if (sck_rise) begin
      // enters at the top so the first bit ends at bit zero
      shift_q <= {sin_s, shift_q[8:1]}; // see RULE5 RULE18
    end
  end

  // output stage follows bit zero on falling edges, or the latch
  // straight after a read-back load
  always_ff @(posedge clk) begin
    if (!rstn) begin
      sod_q <= 1'b0;
    end else if (serial_mode && readback_strobe_s) begin
      sod_q <= latch_q[0]; // see RULE9
    end else if (sck_fall) begin
      sod_q <= shift_q[0]; // see RULE6
    end
  end

  // the fine bit zero pin turns into the serial output in serial mode
  assign fine_sel_0_out = sod_q;
  assign fine_sel_0_oe  = serial_mode; // see RULE7

  // gain latch; the pin strobe wins over a software write
  always_ff @(posedge clk) begin
    if (!rstn) begin
      latch_q <= `GWC_LATCH_RST; // see RULE21
    end else if (serial_mode && load_in_strobe_s) begin
      latch_q <= shift_q; // see RULE8
    end else if (apb_wr && paddr == `GWC_OFS_GAIN) begin
      latch_q <= pwdata[`GWC_WORD_W-1:0];
    end
  end

  // active word; unused pins have no path in serial mode
  always_comb begin
    if (serial_mode) begin
      next_word = latch_q; // see RULE10 RULE1
    end else begin
      next_word = {dir_s, coarse_s, fine_s}; // see RULE11 RULE12 RULE13
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      gain_word   <= `GWC_LATCH_RST;
      gain_tenths <= '0;
    end else begin
      gain_word   <= next_word;
      gain_tenths <= word_tenths(next_word); // see RULE2
    end
  end

  // powerdown leaves the digital section and the latch running
  always_ff @(posedge clk) begin
    if (!rstn) begin
      power_down <= 1'b0;
    end else begin
      power_down <= pdn_s || ctrl_force_pd; // see RULE14
    end
  end

  // apb slave: zero wait states, data prepared in the setup cycle
  assign apb_setup = psel && !penable;
  assign apb_wr    = psel && penable && pwrite;
  assign pready    = 1'b1;

  always_comb begin
    hit        = 1'b1;
    next_rdata = 32'h0000_0000;
    case (paddr)
      `GWC_OFS_CTRL: begin
        next_rdata[`GWC_CTRL_SER_ONLY] = ctrl_ser_only;
        next_rdata[`GWC_CTRL_FORCE_PD] = ctrl_force_pd;
      end
      `GWC_OFS_GAIN: begin
        next_rdata[`GWC_WORD_W-1:0] = latch_q;
      end
      `GWC_OFS_SHIFT: begin
        next_rdata[`GWC_WORD_W-1:0] = shift_q;
      end
      `GWC_OFS_STATUS: begin
        next_rdata[`GWC_WORD_W-1:0] = gain_word;
        next_rdata[`GWC_ST_MODE]    = serial_mode;
        next_rdata[`GWC_ST_PD]      = power_down;
        next_rdata[`GWC_ST_SCK]     = sck_s;
        next_rdata[`GWC_ST_TENTHS_MSB:`GWC_ST_TENTHS_LSB] = gain_tenths;
      end
      default: begin
        hit = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (apb_setup) begin
      prdata  <= pwrite ? 32'h0000_0000 : next_rdata;
      pslverr <= !hit;
    end
  end

  // control register; reset picks the built variant
  always_ff @(posedge clk) begin
    if (!rstn) begin
      ctrl_ser_only <= SERIAL_ONLY;
      ctrl_force_pd <= 1'b0;
    end else if (apb_wr && paddr == `GWC_OFS_CTRL) begin
      // the serial-only variant cannot be unlocked by software
      ctrl_ser_only <= SERIAL_ONLY || pwdata[`GWC_CTRL_SER_ONLY]; // see RULE4
      ctrl_force_pd <= pwdata[`GWC_CTRL_FORCE_PD];
    end
  end
endmodule

// >>> tb/gwc_ctl_model.sv
// Purpose: controller on the serial side of the gain word pins
// Assumes: link clock period 64 ns while sending, 78 ns while fetching, idle low
// Notes:   half-ns offset keeps link edges off the system clock edges
`timescale 1ns/1ps
module gwc_ctl_model (
  output logic      sck,
  output logic      serial_in,
  output logic      ld,
  output logic      rb,
  input  wire logic serial_out
);
  initial {sck, serial_in, ld, rb} = 4'h0;
  task automatic tick;
    #16 sck = 1'b1;
    #32 sck = 1'b0;
  endtask
  task automatic send(input logic [8:0] w);
    #0.5;
    for (int i = 0; i < 9; i++) begin
      serial_in = w[i];
      tick();
      #16;
    end
    // released data line must not keep showing the last bit
    serial_in = ~w[8];
    ld = 1'b1;
    #60 ld = 1'b0;
  endtask
  task automatic fetch(output logic [8:0] w);
    #0.5 rb = 1'b1;
    #60 rb = 1'b0;
    for (int i = 0; i < 9; i++) begin
      #30 w[i] = serial_out;
      tick();
    end
  endtask
endmodule

// >>> tb/gwc_gain_ctrl_chk.sv
// Purpose: port assertions for the gain word control block
// Assumes: serial-only bit is set only while the pin selects serial
// Notes:   bound after the module
`timescale 1ns/1ps
module gwc_chk (
  input wire logic                 clk,
  input wire logic                 rstn,
  input wire logic [7:0]           paddr,
  input wire logic                 psel,
  input wire logic                 penable,
  input wire logic                 pready,
  input wire logic                 pslverr,
  input wire logic                 interface_select,
  input wire logic                 power_down_in,
  input wire logic                 direction_select,
  input wire logic                 coarse_sel_3,
  input wire logic                 coarse_sel_2,
  input wire logic                 coarse_sel_1,
  input wire logic                 coarse_sel_0,
  input wire logic                 fine_sel_3,
  input wire logic                 fine_sel_2,
  input wire logic                 fine_sel_1,
  input wire logic                 fine_sel_0_in,
  input wire logic                 fine_sel_0_out,
  input wire logic                 fine_sel_0_oe,
  input wire gwc_pkg::gwc_word_t   gain_word,
  input wire gwc_pkg::gwc_tenths_t gain_tenths,
  input wire logic                 power_down,
  input wire logic                 serial_mode
);
  import gwc_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  gwc_word_t pw;
  assign pw = {direction_select, coarse_sel_3, coarse_sel_2, coarse_sel_1,
               coarse_sel_0, fine_sel_3, fine_sel_2, fine_sel_1,
               fine_sel_0_in};
  function automatic gwc_tenths_t tn(gwc_word_t w);
    gwc_tenths_t t;
    t = {2'h0, 8'(w[7:4] * 8'h0f + w[3:0])};
    return w[8] ? -t : t;
  endfunction
  sequence par_settled;
    (!serial_mode && $stable(pw))[*6];
  endsequence
  // strobe low and no bus traffic long enough for the pipeline to drain
  sequence ser_quiet;
    (serial_mode && !coarse_sel_2 && !psel)[*8];
  endsequence
  par_word_a: assert property (
    par_settled |-> gain_word == pw) else $error("parallel word");
  ser_hold_a: assert property (
    ser_quiet |=> $stable(gain_word)) else $error("serial word moved");
  tenths_a: assert property (
    $stable(gain_word)[*3] |-> gain_tenths == tn(gain_word))
    else $error("tenths wrong");
  mode_sel_a: assert property (
    $stable(interface_select)[*4] |-> serial_mode == interface_select)
    else $error("mode wrong");
  rb_out_a: assert property (
    (serial_mode && coarse_sel_0)[*4] |-> fine_sel_0_out == gain_word[0])
    else $error("read-back output wrong");
  out_en_a: assert property (
    fine_sel_0_oe == serial_mode) else $error("output enable wrong");
  sod_cause_a: assert property (
    $changed(fine_sel_0_out) |-> !$past(fine_sel_2, 2) ||
    $past(coarse_sel_0, 2)) else $error("serial out moved");
  pd_follow_a: assert property (
    power_down_in[*4] |-> power_down) else $error("no powerdown");
  bus_ready_a: assert property (
    psel && penable |-> pready) else $error("no ready");
  bus_err_a: assert property (psel && penable |->
    pslverr == !(paddr inside {8'h00, 8'h04, 8'h08, 8'h0c}))
    else $error("slave error wrong");
endmodule
bind gwc_gain_ctrl gwc_chk u_chk (.*);

// >>> tb/gwc_gain_ctrl_test.sv
// Purpose: self-checking bench for the gain word control block
// Assumes: pulls resolved here, select high, other pins low
// Notes:   seen and expected values paired from queues
`timescale 1ns/1ps
module gwc_gain_ctrl_test;
  import gwc_pkg::*;
  logic        clk = 1'b0;
  logic        rstn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic        pd_in = 1'b0;
  logic        isel = 1'b1;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready, pslverr, oe, serial_out, sck, serial_in, ld, rb, pd, smode;
  logic [8:0]  pv = 9'h000;
  logic [8:0]  w, r;
  gwc_word_t   gw;
  gwc_tenths_t gt;
  int          bad_count = 0;
  int          n_checks = 0;
  logic [31:0] expq[$], seenq[$];
  always #2.5 clk = ~clk;
  gwc_gain_ctrl dut (.clk(clk), .rstn(rstn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .interface_select(isel),
    .power_down_in(pd_in), .direction_select(pv[8]), .coarse_sel_3(pv[7]),
    .coarse_sel_2(isel ? ld : pv[6]), .coarse_sel_1(isel ? serial_in : pv[5]),
    .coarse_sel_0(isel ? rb : pv[4]), .fine_sel_3(pv[3]),
    .fine_sel_2(isel ? sck : pv[2]), .fine_sel_1(pv[1]),
    .fine_sel_0_in(oe ? serial_out : pv[0]), .fine_sel_0_out(serial_out),
    .fine_sel_0_oe(oe), .gain_word(gw), .gain_tenths(gt),
    .power_down(pd), .serial_mode(smode));
  gwc_ctl_model ctl (.sck(sck), .serial_in(serial_in), .ld(ld), .rb(rb), .serial_out(serial_out));
  function automatic logic [31:0] dbt(logic [8:0] v);
    int t;
    t = v[7:4] * 15 + v[3:0];
    return 32'(v[8] ? -t : t);
  endfunction
  task automatic chk(logic [31:0] seen, logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH %0t seen %h exp %h", $time, seen, exp);
    end
  endtask
  task automatic note(logic [31:0] e, logic [31:0] v);
    expq.push_back(e);
    seenq.push_back(v);
  endtask
  always @(posedge clk) begin
    while (seenq.size() > 0) chk(seenq.pop_front(), expq.pop_front());
  end
  task automatic apb(logic wr, logic [7:0] a, logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic results;
    if (bad_count == 0 && n_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    #50000;
    bad_count++;
    results();
  end
  initial begin
    void'($urandom(74));
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
    repeat (2) @(posedge clk);
    note(32'h1, 32'({gw, smode}));
    apb(1'b1, 8'h04, 32'h100);
    apb(1'b0, 8'h04, 32'h0);
    note(32'h100, prdata);
    repeat (4) @(posedge clk);
    note(32'h0, 32'(gt));
    apb(1'b0, 8'h10, 32'h0);
    note(32'h0, prdata);
    note(32'h1, 32'(pslverr));
    for (int i = 0; i < 3; i++) begin
      w = 9'($urandom);
      pv <= 9'($urandom);
      ctl.send(w);
      repeat (8) @(posedge clk);
      note(32'(w), 32'(gw));
      ctl.fetch(r);
      @(posedge clk);
      note(32'(w), 32'(r));
    end
    // the last fetch shifted nine copies of the idle data level in
    apb(1'b0, 8'h08, 32'h0);
    note(32'({9{~w[8]}}), prdata);
    apb(1'b1, 8'h00, 32'h1);
    apb(1'b0, 8'h00, 32'h0);
    note(32'h1, prdata);
    apb(1'b1, 8'h00, 32'h0);
    isel <= 1'b0;
    for (int i = 0; i < 5; i++) begin
      pv <= i == 0 ? 9'h0ff : i == 1 ? 9'h1ff : 9'($urandom);
      repeat (8) @(posedge clk);
      note(32'(pv), 32'({smode, gw}));
      note(dbt(pv), 32'(gt));
    end
    pd_in <= 1'b1;
    repeat (6) @(posedge clk);
    note(32'h1, 32'(pd));
    pd_in <= 1'b0;
    repeat (6) @(posedge clk);
    note(32'h0, 32'(pd));
    // software powerdown, then the whole status word in parallel mode
    apb(1'b1, 8'h00, 32'h2);
    apb(1'b0, 8'h0c, 32'h0);
    note({6'h00, 10'(dbt(pv)), 4'h0, pv[2], 2'b10, pv}, prdata);
    apb(1'b0, 8'h00, 32'h0);
    note(32'h2, prdata);
    note(32'h1, 32'(pd));
    apb(1'b1, 8'h00, 32'h0);
    repeat (4) @(posedge clk);
    note(32'h0, 32'(pd));
    repeat (2) @(posedge clk);
    results();
  end
endmodule
